//--- hw/fault_mon_pkg.sv
// Purpose: Shared constants and types of the cell fault monitor
// Assumes: 50 MHz system clock, registers reached over APB
// Notes: Register offsets are word indices; byte address is four times the index
package fault_mon_pkg;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_CELL_VOLTAGE_OP = 8'h02; // Trigger, clear, option bits
  localparam logic [7:0] IDX_CELL_SEL_HI = 8'h04; // Cells 16..9 enable
  localparam logic [7:0] IDX_CELL_SEL_LO = 8'h05; // Cells 8..1 enable
  localparam logic [7:0] IDX_OV_TH = 8'h06;
  localparam logic [7:0] IDX_UV_TH = 8'h07;
  localparam logic [7:0] IDX_SPREAD_TH = 8'h08;
  localparam logic [7:0] IDX_DOC_TH = 8'h0b;
  localparam logic [7:0] IDX_OC_DELAY = 8'h0d;
  localparam logic [7:0] IDX_OC_CONNECT = 8'h0e;
  localparam logic [7:0] IDX_COC_TH = 8'h0f;
  localparam logic [7:0] IDX_FAULT = 8'h63;
  localparam logic [7:0] IDX_FAULT2 = 8'h66;
  localparam logic [7:0] IDX_DIRECTION = 8'h67;
  localparam logic [7:0] IDX_MODE = 8'h70; // Scan mode, continuous scan, averaging
  localparam logic [7:0] IDX_CUR_TRIG = 8'h71; // Pack current trigger
  localparam logic [7:0] IDX_SWITCH = 8'h72; // Charge / discharge switch control
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h73;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h74;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h75;
  localparam logic [7:0] IDX_CUR_RESULT = 8'h76;
  localparam logic [7:0] IDX_SPREAD_RESULT = 8'h77;

  // ==========================================================
  // Field positions
  localparam int VOP_TRIGGER = 0;
  localparam int VOP_CLEAR = 1;
  localparam int VOP_CHG_UV = 5; // charge_during_undervoltage option
  localparam int VOP_DIS_OV = 6; // discharge_during_overvoltage option
  localparam int CONN_COC = 2;
  localparam int CONN_DOC = 7;
  localparam int FLT_OV = 0;
  localparam int FLT_UV = 1;
  localparam int FLT_DOC = 3;
  localparam int FLT_COC = 4;
  localparam int FLT2_SPREAD = 3;
  localparam int DIR_CHG = 6;
  localparam int DIR_DIS = 7;
  localparam int MODE_SCAN = 0;
  localparam int MODE_CONT = 1;
  localparam int MODE_AVG_LO = 2; // Averaging exponent, 3 bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_FAULT = 1;
  localparam int IRQ_SHUTOFF = 2;
  localparam int IRQ_BITS = 3;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_OV_TH = 8'hff;
  localparam logic [7:0] RST_UV_TH = 8'h00;
  localparam logic [7:0] RST_SPREAD_TH = 8'hff;
  localparam logic [7:0] RST_OC_TH = 8'hff;
  localparam logic [7:0] RST_OC_DELAY = 8'h11;
  localparam logic [7:0] RST_CELL_SEL = 8'hff;
  localparam logic [1:0] RST_SWITCH = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MEAS_BASE_NS = 2000; // One unaveraged conversion
  localparam int SCAN_GAP_NS = 1000000; // Pause between continuous scans
  localparam int MEAS_BASE_CYC = (MEAS_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_GAP_CYC = (SCAN_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic signed [8:0] DIR_LIMIT = 9'sh002; // Current codes above this one count as flowing
  localparam int TIMER_W = 24;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_MEAS = 2'b10
  } phase_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [9:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

endpackage

//--- hw/cell_fault_monitor.sv
// Purpose: Cell and pack current fault comparison with switch shut-off
// Assumes: Converter results are 8-bit codes on the same scale as thresholds
// Notes: Function
//
// Our own choice: the APB register port.
`timescale 1ns/1ps

module cell_fault_monitor #(
  parameter int CELLS = 16, // Cells managed
  parameter int MEAS_CYC = fault_mon_pkg::MEAS_BASE_CYC, // Unaveraged conversion length
  parameter int GAP_CYC = fault_mon_pkg::SCAN_GAP_CYC // Pause in continuous scan
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire fault_mon_pkg::apb_req_t apb_req,
  output fault_mon_pkg::apb_rsp_t apb_rsp,
  input wire logic [CELLS*8-1:0] cell_voltage,
  input wire logic signed [8:0] pack_current,
  output logic charge_switch,
  output logic discharge_switch,
  output logic alert_output,
  output logic irq
);
  import fault_mon_pkg::*;

  // ==========================================================
  // Elaboration checks
  generate
    if (CELLS < 2 || CELLS > 16) begin : g_bad_cells
      $error("CELLS must be 2..16");
    end
    if (MEAS_CYC < 1 || GAP_CYC < 1 || (MEAS_CYC << 7) >= (1 << TIMER_W) || GAP_CYC >= (1 << TIMER_W)) begin : g_bad_time
      $error("Timing parameters out of range");
    end
  endgenerate

  // ==========================================================
  // State
  typedef struct packed {
    phase_t phase; // Idle or measuring
    logic do_cells; // Current measurement includes cells
    logic do_current; // Current measurement includes pack current
    logic [TIMER_W-1:0] timer; // Conversion or scan-gap countdown
    logic [7:0] ov_th;
    logic [7:0] uv_th;
    logic [7:0] spread_th;
    logic [7:0] doc_th;
    logic [7:0] coc_th;
    logic [7:0] oc_delay; // Discharge delay high nibble, charge low
    logic [7:0] oc_connect;
    logic [1:0] vop_opt; // Stored option bits of the operation register
    logic [15:0] cell_sel;
    logic scan_mode;
    logic cont_scan;
    logic [2:0] avg;
    logic charge_sw;
    logic discharge_sw;
    logic overvoltage_flag;
    logic undervoltage_flag;
    logic cell_spread_flag;
    logic discharge_overcurrent_flag;
    logic charge_overcurrent_flag;
    logic charge_current_seen;
    logic discharge_current_seen;
    logic [3:0] doc_cnt; // Consecutive discharge violations
    logic [3:0] coc_cnt; // Consecutive charge violations
    logic signed [8:0] cur_res;
    logic [7:0] spread_res;
    logic [IRQ_BITS-1:0] irq_st;
    logic [IRQ_BITS-1:0] irq_en;
    logic [31:0] prdata;
  } state_t;

  state_t q_r; // Registered state
  state_t q_nxt; // Next state

  // ==========================================================
  // Per-cell comparison
  logic [CELLS-1:0] ov_hit; // Enabled cell above overvoltage
  logic [CELLS-1:0] uv_hit; // Enabled cell below undervoltage
  logic [CELLS-1:0][7:0] hi_val; // Enabled value or zero
  logic [CELLS-1:0][7:0] lo_val; // Enabled value or full scale

  genvar gi;
  generate
    for (gi = 0; gi < CELLS; gi++) begin : g_cell
      logic [7:0] v;
      assign v = cell_voltage[gi*8 +: 8];
      assign ov_hit[gi] = q_r.cell_sel[gi] && (v > q_r.ov_th);
      assign uv_hit[gi] = q_r.cell_sel[gi] && (v < q_r.uv_th);
      assign hi_val[gi] = q_r.cell_sel[gi] ? v : 8'h00;
      assign lo_val[gi] = q_r.cell_sel[gi] ? v : 8'hff;
    end
  endgenerate

  logic [7:0] cell_max; // Highest enabled cell
  logic [7:0] cell_min; // Lowest enabled cell
  logic [7:0] spread; // Highest minus lowest

  // Reduction over enabled cells; no enabled cell gives zero spread
  always_comb begin
    cell_max = 8'h00;
    cell_min = 8'hff;
    for (int i = 0; i < CELLS; i++) begin
      if (hi_val[i] > cell_max) begin
        cell_max = hi_val[i];
      end
      if (lo_val[i] < cell_min) begin
        cell_min = lo_val[i];
      end
    end
    spread = (cell_max > cell_min) ? (cell_max - cell_min) : 8'h00;
  end

  // ==========================================================
  // Pack current comparison
  logic signed [8:0] neg_cur; // Discharge magnitude
  logic coc_hit; // Charge current above its threshold
  logic doc_hit; // Discharge current above its threshold
  logic [3:0] doc_need; // Violations required, zero treated as one
  logic [3:0] coc_need;

  assign neg_cur = -pack_current;
  assign coc_hit = (pack_current > 9'sh000) && (pack_current[7:0] > q_r.coc_th);
  assign doc_hit = (pack_current < 9'sh000) && ({1'b0, q_r.doc_th} < neg_cur);
  assign doc_need = (q_r.oc_delay[7:4] == 4'h0) ? 4'h1 : q_r.oc_delay[7:4];
  assign coc_need = (q_r.oc_delay[3:0] == 4'h0) ? 4'h1 : q_r.oc_delay[3:0];

  // ==========================================================
  // Bus decode
  logic [7:0] idx; // Word index of the access
  logic wr_en; // Write access phase
  logic setup; // Setup phase, read data captured here
  logic mapped; // Address decodes to a register
  logic [7:0] rd_val; // Read value of the addressed register

  assign idx = apb_req.paddr[9:2];
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign setup = apb_req.psel && !apb_req.penable;

  // Read mux; write-only and trigger bits read zero
  always_comb begin
    mapped = 1'b1;
    rd_val = 8'h00;
    unique case (idx)
      IDX_CELL_VOLTAGE_OP: rd_val = {1'b0, q_r.vop_opt[1], q_r.vop_opt[0], 5'h00};
      IDX_CELL_SEL_HI: rd_val = q_r.cell_sel[15:8];
      IDX_CELL_SEL_LO: rd_val = q_r.cell_sel[7:0];
      IDX_OV_TH: rd_val = q_r.ov_th;
      IDX_UV_TH: rd_val = q_r.uv_th;
      IDX_SPREAD_TH: rd_val = q_r.spread_th;
      IDX_DOC_TH: rd_val = q_r.doc_th;
      IDX_OC_DELAY: rd_val = q_r.oc_delay;
      IDX_OC_CONNECT: rd_val = q_r.oc_connect;
      IDX_COC_TH: rd_val = q_r.coc_th;
      IDX_FAULT: begin
        rd_val[FLT_OV] = q_r.overvoltage_flag;
        rd_val[FLT_UV] = q_r.undervoltage_flag;
        rd_val[FLT_DOC] = q_r.discharge_overcurrent_flag;
        rd_val[FLT_COC] = q_r.charge_overcurrent_flag;
      end
      IDX_FAULT2: rd_val[FLT2_SPREAD] = q_r.cell_spread_flag;
      IDX_DIRECTION: begin
        rd_val[DIR_CHG] = q_r.charge_current_seen;
        rd_val[DIR_DIS] = q_r.discharge_current_seen;
      end
      IDX_MODE: begin
        rd_val[MODE_SCAN] = q_r.scan_mode;
        rd_val[MODE_CONT] = q_r.cont_scan;
        rd_val[MODE_AVG_LO +: 3] = q_r.avg;
      end
      IDX_CUR_TRIG: rd_val = 8'h00;
      IDX_SWITCH: rd_val = {6'h00, q_r.discharge_sw, q_r.charge_sw};
      IDX_IRQ_STATUS: rd_val = {5'h00, q_r.irq_st};
      IDX_IRQ_ENABLE: rd_val = {5'h00, q_r.irq_en};
      IDX_IRQ_CLEAR: rd_val = 8'h00;
      IDX_CUR_RESULT: rd_val = q_r.cur_res[7:0];
      IDX_SPREAD_RESULT: rd_val = q_r.spread_res;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // Next-state logic
  logic start_cells; // Individual cell trigger written
  logic start_cur; // Individual current trigger written
  logic clear_faults; // Clear-fault bit written
  logic [IRQ_BITS-1:0] irq_set; // Events this cycle
  logic [IRQ_BITS-1:0] irq_clr; // Software clear this cycle
  logic shut; // Switches cut by a fault this cycle
  logic fault_new; // Any fault detected this cycle, even if its flag was already set

  always_comb begin
    q_nxt = q_r;
    start_cells = 1'b0;
    start_cur = 1'b0;
    clear_faults = 1'b0;
    irq_set = '0;
    irq_clr = '0;
    shut = 1'b0;
    fault_new = 1'b0;

    // Capture read data in setup so it comes from a flip-flop
    if (setup) begin
      q_nxt.prdata = {24'h000000, rd_val};
    end

    // Register writes take effect in the access phase
    if (wr_en && mapped) begin
      unique case (idx)
        IDX_CELL_VOLTAGE_OP: begin
          start_cells = apb_req.pwdata[VOP_TRIGGER];
          clear_faults = apb_req.pwdata[VOP_CLEAR];
          q_nxt.vop_opt = {apb_req.pwdata[VOP_DIS_OV], apb_req.pwdata[VOP_CHG_UV]};
        end
        IDX_CELL_SEL_HI: q_nxt.cell_sel[15:8] = apb_req.pwdata[7:0];
        IDX_CELL_SEL_LO: q_nxt.cell_sel[7:0] = apb_req.pwdata[7:0];
        IDX_OV_TH: q_nxt.ov_th = apb_req.pwdata[7:0];
        IDX_UV_TH: q_nxt.uv_th = apb_req.pwdata[7:0];
        IDX_SPREAD_TH: q_nxt.spread_th = apb_req.pwdata[7:0];
        IDX_DOC_TH: q_nxt.doc_th = apb_req.pwdata[7:0];
        IDX_OC_DELAY: q_nxt.oc_delay = apb_req.pwdata[7:0];
        IDX_OC_CONNECT: q_nxt.oc_connect = apb_req.pwdata[7:0];
        IDX_COC_TH: q_nxt.coc_th = apb_req.pwdata[7:0];
        IDX_MODE: begin
          q_nxt.scan_mode = apb_req.pwdata[MODE_SCAN];
          // Continuous scan cannot run in idle mode
          q_nxt.cont_scan = apb_req.pwdata[MODE_CONT] && apb_req.pwdata[MODE_SCAN];
          q_nxt.avg = apb_req.pwdata[MODE_AVG_LO +: 3];
          q_nxt.timer = '0;
        end
        IDX_CUR_TRIG: start_cur = apb_req.pwdata[0];
        IDX_SWITCH: begin
          // Host may turn switches back on even while a fault persists
          q_nxt.charge_sw = apb_req.pwdata[0];
          q_nxt.discharge_sw = apb_req.pwdata[1];
        end
        IDX_IRQ_ENABLE: q_nxt.irq_en = apb_req.pwdata[IRQ_BITS-1:0];
        IDX_IRQ_CLEAR: irq_clr = apb_req.pwdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end

    // Clear first so a flag set in the same cycle survives
    if (clear_faults) begin
      q_nxt.overvoltage_flag = 1'b0;
      q_nxt.undervoltage_flag = 1'b0;
      q_nxt.cell_spread_flag = 1'b0;
      q_nxt.discharge_overcurrent_flag = 1'b0;
      q_nxt.charge_overcurrent_flag = 1'b0;
      q_nxt.doc_cnt = 4'h0;
      q_nxt.coc_cnt = 4'h0;
    end

    unique case (q_r.phase)
      PH_IDLE: begin
        // Triggers written while busy are dropped
        if (start_cells || start_cur) begin
          q_nxt.phase = PH_MEAS;
          q_nxt.do_cells = start_cells;
          q_nxt.do_current = start_cur;
          q_nxt.timer = TIMER_W'(MEAS_CYC) << q_nxt.avg;
        end else if (q_r.cont_scan && q_r.scan_mode) begin
          if (q_r.timer == '0) begin
            // System scan measures cells and current together
            q_nxt.phase = PH_MEAS;
            q_nxt.do_cells = 1'b1;
            q_nxt.do_current = 1'b1;
            q_nxt.timer = TIMER_W'(MEAS_CYC) << q_r.avg;
          end else begin
            q_nxt.timer = q_r.timer - 1'b1;
          end
        end
      end
      PH_MEAS: begin
        if (q_r.timer > TIMER_W'(1)) begin
          q_nxt.timer = q_r.timer - 1'b1;
        end else begin
          // Conversion done: faults are judged only here
          q_nxt.phase = PH_IDLE;
          q_nxt.timer = TIMER_W'(GAP_CYC);
          irq_set[IRQ_DONE] = 1'b1;
          if (q_r.do_cells) begin
            q_nxt.spread_res = spread;
            if (|ov_hit) begin
              fault_new = 1'b1;
              q_nxt.overvoltage_flag = 1'b1;
              shut = shut || (q_r.scan_mode && q_r.charge_current_seen);
            end
            if (|uv_hit) begin
              fault_new = 1'b1;
              q_nxt.undervoltage_flag = 1'b1;
              shut = shut || (q_r.scan_mode && q_r.discharge_current_seen);
            end
            if (spread > q_r.spread_th) begin
              fault_new = 1'b1;
              q_nxt.cell_spread_flag = 1'b1;
            end
          end
          if (q_r.do_current) begin
            q_nxt.cur_res = pack_current;
            // Direction only tracked in scan mode
            q_nxt.charge_current_seen = q_r.scan_mode && (pack_current > DIR_LIMIT);
            q_nxt.discharge_current_seen = q_r.scan_mode && (neg_cur > DIR_LIMIT);
            // Counters run in every mode but only gate in continuous scan, else one hit suffices
            q_nxt.doc_cnt = doc_hit ? q_r.doc_cnt + 4'h1 : 4'h0;
            q_nxt.coc_cnt = coc_hit ? q_r.coc_cnt + 4'h1 : 4'h0;
            if (doc_hit && (!q_r.cont_scan || (q_r.doc_cnt + 4'h1 >= doc_need))) begin
              fault_new = 1'b1;
              q_nxt.discharge_overcurrent_flag = 1'b1;
              q_nxt.doc_cnt = 4'h0;
              shut = shut || (q_r.scan_mode && q_r.oc_connect[CONN_DOC]);
            end
            if (coc_hit && (!q_r.cont_scan || (q_r.coc_cnt + 4'h1 >= coc_need))) begin
              fault_new = 1'b1;
              q_nxt.charge_overcurrent_flag = 1'b1;
              q_nxt.coc_cnt = 4'h0;
              shut = shut || (q_r.scan_mode && q_r.oc_connect[CONN_COC]);
            end
          end
          // Cut switches and stop a continuous scan; idle never cuts
          if (shut) begin
            q_nxt.charge_sw = 1'b0;
            q_nxt.discharge_sw = 1'b0;
            q_nxt.cont_scan = 1'b0;
          end
        end
      end
    endcase

    // Sticky interrupt status, set wins over clear
    irq_set[IRQ_FAULT] = fault_new;
    irq_set[IRQ_SHUTOFF] = shut;
    q_nxt.irq_st = (q_r.irq_st & ~irq_clr) | irq_set;
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q_r <= '0;
      q_r.phase <= PH_IDLE;
      q_r.ov_th <= RST_OV_TH;
      q_r.uv_th <= RST_UV_TH;
      q_r.spread_th <= RST_SPREAD_TH;
      q_r.doc_th <= RST_OC_TH;
      q_r.coc_th <= RST_OC_TH;
      q_r.oc_delay <= RST_OC_DELAY;
      q_r.cell_sel <= {RST_CELL_SEL, RST_CELL_SEL};
      q_r.charge_sw <= RST_SWITCH[0];
      q_r.discharge_sw <= RST_SWITCH[1];
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign apb_rsp.pready = 1'b1; // Zero wait states
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign apb_rsp.prdata = q_r.prdata;
  assign charge_switch = q_r.charge_sw;
  assign discharge_switch = q_r.discharge_sw;
  assign alert_output = (q_r.phase == PH_MEAS);
  assign irq = |(q_r.irq_st & q_r.irq_en);

endmodule // cell_fault_monitor

//--- tb/cell_fault_props.sv
// Purpose: Port-level checks of the cell fault monitor
// Assumes: Single clock domain, async active-high reset
// Notes: Sees only the top module ports
`timescale 1ns/1ps

module cell_fault_props #(
  parameter int CELLS = 16,
  parameter int MEAS_CYC = 100,
  parameter int GAP_CYC = 50000
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire fault_mon_pkg::apb_req_t apb_req,
  input wire fault_mon_pkg::apb_rsp_t apb_rsp,
  input wire logic [CELLS*8-1:0] cell_voltage,
  input wire logic signed [8:0] pack_current,
  input wire logic charge_switch,
  input wire logic discharge_switch,
  input wire logic alert_output,
  input wire logic irq
);
  import fault_mon_pkg::*;
  // ==========================================================
  // Helper logic
  logic wr_any; // Any write taking effect
  logic sw_wr; // Host write to switch control
  logic trig; // Measurement trigger write
  logic [15:0] run_r; // Cycles alert has been high
  assign wr_any = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign sw_wr = wr_any && (apb_req.paddr[9:2] == IDX_SWITCH);
  assign trig = wr_any && apb_req.pwdata[0] && (apb_req.paddr[9:2] == IDX_CELL_VOLTAGE_OP ||
    apb_req.paddr[9:2] == IDX_CUR_TRIG);
  // Alert run length, cleared whenever alert is low
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      run_r <= '0;
    end else begin
      run_r <= alert_output ? run_r + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  chk_pready_high: assert property (apb_rsp.pready)
    else $error("pready low");
  chk_err_access: assert property (apb_rsp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("pslverr outside access");
  chk_rdata_upper: assert property (apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  chk_alert_start: assert property (trig && !alert_output |=> alert_output)
    else $error("alert did not follow trigger");
  chk_alert_len: assert property ($fell(alert_output) |->
    run_r >= MEAS_CYC && run_r <= (MEAS_CYC << 7))
    else $error("alert length out of range");
  chk_switch_cut: assert property ($fell(charge_switch) || $fell(discharge_switch) |->
    $fell(alert_output) || $past(sw_wr))
    else $error("switch fell outside measurement end");
  chk_switch_on: assert property ($rose(charge_switch) || $rose(discharge_switch) |-> $past(sw_wr))
    else $error("switch rose without host write");
  chk_irq_rise: assert property ($rose(irq) |-> $fell(alert_output) || $past(wr_any))
    else $error("irq rose without cause");
endmodule // cell_fault_props

bind cell_fault_monitor cell_fault_props #(.CELLS(CELLS), .MEAS_CYC(MEAS_CYC), .GAP_CYC(GAP_CYC)) u_props (
  .ref_clk(ref_clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cell_voltage(cell_voltage), .pack_current(pack_current), .charge_switch(charge_switch),
  .discharge_switch(discharge_switch), .alert_output(alert_output), .irq(irq));

//--- tb/cell_source.sv
// Purpose: Converter-side model giving cell and pack current codes
// Assumes: Codes change only between measurements
// Notes: Values move on a rising edge by non-blocking assignment
`timescale 1ns/1ps

module cell_source #(
  parameter int CELLS = 16
) (
  input wire logic ref_clk,
  output logic [CELLS*8-1:0] cell_voltage,
  output logic signed [8:0] pack_current
);
  // Mid-scale start so no threshold trips by accident
  initial begin
    cell_voltage = {CELLS{8'h80}};
    pack_current = 9'sh000;
  end
  task automatic set_cell(input int i, input logic [7:0] v);
    @(posedge ref_clk);
    cell_voltage[i*8+:8] <= v;
  endtask
  task automatic set_all(input logic [7:0] v);
    @(posedge ref_clk);
    cell_voltage <= {CELLS{v}};
  endtask
  task automatic set_cur(input logic signed [8:0] c);
    @(posedge ref_clk);
    pack_current <= c;
  endtask
endmodule // cell_source

//--- tb/tb_top.sv
// Purpose: Register-level test of the cell fault monitor
// Assumes: Shortened conversion length
// Notes: Stimulus after time zero by non-blocking assignment at rising edges
`timescale 1ns/1ps

module tb_top;
  import fault_mon_pkg::*;
  localparam int MC = 2; // Short conversion keeps the run brief
  localparam int GAP = 5; // Short pause between continuous scans
  logic ref_clk = 1'b0;
  logic reset; // Raised at time zero by the main sequence so the async reset sees an edge
  apb_req_t apb_req = '0;
  apb_rsp_t apb_rsp;
  logic [127:0] cell_voltage;
  logic signed [8:0] pack_current;
  logic charge_switch, discharge_switch, alert_output, irq;
  int failures = 0;
  int check_count = 0;
  int cyc; // Alert high cycles of last measurement
  logic last_err; // Error response of last transfer

  cell_source src (.ref_clk(ref_clk), .cell_voltage(cell_voltage), .pack_current(pack_current));
  cell_fault_monitor #(.MEAS_CYC(MC), .GAP_CYC(GAP)) dut (.ref_clk(ref_clk), .reset(reset),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .cell_voltage(cell_voltage), .pack_current(pack_current),
    .charge_switch(charge_switch), .discharge_switch(discharge_switch), .alert_output(alert_output), .irq(irq));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; waits for pready, bounded
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {idx, 2'b00}, pwdata: d};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > 50) begin
        failures++;
        give_verdict();
      end
    end while (apb_rsp.pready !== 1'b1);
    r = apb_rsp.prdata;
    last_err = apb_rsp.pslverr;
    apb_req <= '0;
    #1;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask
  // Trigger and count alert cycles until it drops
  task automatic meas(input logic [7:0] idx);
    int n;
    wr(idx, 32'h1);
    cyc = 0;
    // Alert is already high when the write returns, so look before waiting
    for (n = 0; n < 600; n++) begin
      if (alert_output === 1'b1) cyc++;
      else if (cyc > 0) break;
      @(posedge ref_clk);
      #1;
    end
    if (n >= 600) begin
      failures++;
      give_verdict();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset <= 1'b1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    rdchk(IDX_OV_TH, 32'hff);
    rdchk(IDX_UV_TH, 32'h00);
    rdchk(IDX_SPREAD_TH, 32'hff);
    rdchk(IDX_OC_DELAY, 32'h11);
    rdchk(IDX_SWITCH, 32'h3);
    rdchk(8'h40, 32'h0);
    chk(last_err, 1'b1);
    wr(IDX_OV_TH, 32'h80);
    wr(IDX_UV_TH, 32'h80);
    meas(IDX_CELL_VOLTAGE_OP);
    chk(cyc, MC);
    rdchk(IDX_FAULT, 32'h0);
    src.set_cell(4, 8'h81);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT, 32'h1);
    chk(charge_switch, 1'b1);
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    rdchk(IDX_FAULT, 32'h0);
    src.set_cell(4, 8'h80);
    src.set_cell(9, 8'h7f);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT, 32'h2);
    wr(IDX_CELL_SEL_HI, 32'hfd);
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT, 32'h0);
    wr(IDX_CELL_SEL_HI, 32'hff);
    wr(IDX_OV_TH, 32'hff);
    wr(IDX_UV_TH, 32'h00);
    wr(IDX_SPREAD_TH, 32'h1f);
    src.set_cell(0, 8'h70);
    src.set_cell(1, 8'h90);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT2, 32'h8);
    rdchk(IDX_SPREAD_RESULT, 32'h20);
    wr(IDX_SPREAD_TH, 32'h20);
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT2, 32'h0);
    src.set_cur(9'sd20);
    src.set_all(8'h80);
    meas(IDX_CUR_TRIG);
    rdchk(IDX_DIRECTION, 32'h0);
    rdchk(IDX_SPREAD_RESULT, 32'h20);
    rdchk(IDX_CUR_RESULT, 32'h14);
    wr(IDX_MODE, 32'h1);
    meas(IDX_CUR_TRIG);
    rdchk(IDX_DIRECTION, 32'h40);
    src.set_cell(4, 8'h81);
    wr(IDX_OV_TH, 32'h80);
    meas(IDX_CELL_VOLTAGE_OP);
    chk({charge_switch, discharge_switch}, 2'b00);
    wr(IDX_SWITCH, 32'h3);
    chk(charge_switch, 1'b1);
    meas(IDX_CELL_VOLTAGE_OP);
    chk({charge_switch, discharge_switch}, 2'b00);
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    wr(IDX_SWITCH, 32'h3);
    wr(IDX_OV_TH, 32'hff);
    wr(IDX_UV_TH, 32'h80);
    src.set_cell(4, 8'h7f);
    meas(IDX_CELL_VOLTAGE_OP);
    rdchk(IDX_FAULT, 32'h2);
    chk(charge_switch, 1'b1);
    src.set_cur(-9'sd20);
    meas(IDX_CUR_TRIG);
    rdchk(IDX_DIRECTION, 32'h80);
    meas(IDX_CELL_VOLTAGE_OP);
    chk({charge_switch, discharge_switch}, 2'b00);
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    wr(IDX_SWITCH, 32'h3);
    wr(IDX_UV_TH, 32'h00);
    wr(IDX_COC_TH, 32'h10);
    wr(IDX_OC_CONNECT, 32'h4);
    src.set_cur(9'sd20);
    meas(IDX_CUR_TRIG);
    rdchk(IDX_FAULT, 32'h10);
    chk({charge_switch, discharge_switch}, 2'b00);
    wr(IDX_IRQ_CLEAR, 32'h7);
    wr(IDX_IRQ_ENABLE, 32'h1);
    chk(irq, 1'b0);
    wr(IDX_MODE, 32'h9);
    meas(IDX_CELL_VOLTAGE_OP);
    chk(cyc, MC << 2);
    chk(irq, 1'b1);
    wr(IDX_IRQ_ENABLE, 32'h0);
    chk(irq, 1'b0);
    wr(IDX_IRQ_ENABLE, 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h1);
    chk(irq, 1'b0);
    // Continuous scan: charge overcurrent needs two consecutive hits
    wr(IDX_CELL_VOLTAGE_OP, 32'h2);
    wr(IDX_SWITCH, 32'h3);
    wr(IDX_OC_DELAY, 32'h12);
    wr(IDX_MODE, 32'h3);
    repeat (4) @(posedge ref_clk);
    rdchk(IDX_FAULT, 32'h0);
    repeat (12) @(posedge ref_clk);
    rdchk(IDX_FAULT, 32'h10);
    chk({charge_switch, discharge_switch}, 2'b00);
    rdchk(IDX_MODE, 32'h1);
    give_verdict();
  end
endmodule // tb_top
